// ===== phy_vendor_config_register.sv
// vendor configuration register of the embedded phy, on a wishbone slave
// assumes a classic wishbone master on clk; datapath blocks sit outside
// line status inputs arrive asynchronously and are synchronised here
// reset and sleep sequencing drive the phy state machine reset level
`timescale 1ns/1ns
`default_nettype none
`include "phy_cfg_defines.svh"

// Function
// - encoder bypass bit skips 4b5b transmit encode and receive decode
// - scrambler bypass bit passes symbols unscrambled both ways
// - alignment bypass bit bypasses descramble, align, decode, encode, scramble
// - signal detect force bit makes the detector report valid signal
// - media select: one is copper, zero is fibre, default copper
// - forced link bit reports good 100M link regardless of line
// - auto reduced power enable, default one, permits automatic power down
// - writing one to state machine reset resets all phy state machines
// - state machine reset bit clears itself when the reset completes
// - preamble suppression, default one, accepts frames without preamble
// - writing one to sleep powers down all but oscillator and clocks
// - waking keeps configuration, state machines restart from reset
// - reserved bits 11,9,8,6,5 read zero and are written zero
// - fields change only by hardware or management access
module phy_vendor_config_register
    import phy_cfg_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire phy_cfg_pkg::cfg_addr_t wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    input wire logic line_signal_detector,
    input wire logic line_link_100,
    output logic encoder_bypass,
    output logic scrambler_bypass,
    output logic alignment_bypass,
    output logic signal_detect_ok,
    output logic media_copper,
    output logic link_100_good,
    output logic auto_reduced_power_enable,
    output logic preamble_suppression,
    output logic state_machine_reset,
    output logic sleep_mode
);
    import phy_cfg_pkg::*;

    cfg_word_t cfg;
    sm_state_t state;
    logic [1:0] line_in;
    logic [1:0] line_clean;
    logic sd_clean;
    logic link_clean;
    logic req;
    logic hit_cfg;
    logic hit_status;
    logic wr_cfg;
    logic state_machine_reset_start;
    logic timer_busy;
    logic timer_done;
    logic wake;
    cfg_word_t next_cfg;
    logic [31:0] rd_word;
    logic rd_req;
    logic timer_start;

    // byte lanes 0 and 1 merged into the old word
    function automatic cfg_word_t lane_merge(input cfg_word_t old,
                                             input logic [15:0] data,
                                             input logic [1:0] sel);
        cfg_word_t r;
        r = old;
        if (sel[0]) begin
            r[7:0] = data[7:0];
        end
        if (sel[1]) begin
            r[15:8] = data[15:8];
        end
        return r;
    endfunction

    // index decode, shared by the read and write paths
    function automatic logic addr_is(input cfg_addr_t a,
                                     input cfg_addr_t off);
        return a == off;
    endfunction

    // a request is taken only while no answer is pending
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    assign hit_cfg = addr_is(wb_adr_i, `CFG_OFF_VENDOR);
    assign hit_status = addr_is(wb_adr_i, `CFG_OFF_STATUS);
    assign wr_cfg = req && wb_we_i && hit_cfg;
    assign rd_req = req && !wb_we_i;

    // merged write value; reserved bits forced to zero
    always_comb begin
        next_cfg = lane_merge(cfg, wb_dat_i[15:0], wb_sel_i[1:0]);
        next_cfg = next_cfg & `CFG_RW_MASK;
        next_cfg[0] = 1'b0;
    end

    // wishbone answer one cycle after the request
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= req && (hit_cfg || hit_status);
        end
    end

    // unmapped index answered with err and no effect
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wb_err_o <= 1'b0;
        end else begin
            wb_err_o <= req && !(hit_cfg || hit_status);
        end
    end

    // read value of the addressed word
    always_comb begin
        rd_word = 32'h0000_0000;
        if (hit_cfg) begin
            rd_word = {16'h0000, cfg & `CFG_RW_MASK};
        end else if (hit_status) begin
            rd_word = {28'h0000000, timer_busy, sleep_mode,
                       sd_clean, link_clean};
        end
    end

    // read data stands only in the ack cycle
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (rd_req) begin
            wb_dat_o <= rd_word;
        end else begin
            wb_dat_o <= 32'h0000_0000;
        end
    end

    // configuration storage
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cfg <= `CFG_RESET_VAL;
        end else begin
            if (wr_cfg) begin
                cfg <= next_cfg;
                // a write of zero leaves the reset bit set while the timer is busy
                if (timer_busy && !next_cfg[`CFG_BIT_STATE_MACHINE_RESET]) begin
                    cfg[`CFG_BIT_STATE_MACHINE_RESET] <= 1'b1;
                end
            end else if (timer_done) begin
                cfg[`CFG_BIT_STATE_MACHINE_RESET] <= 1'b0;
            end
        end
    end

    assign state_machine_reset_start = wr_cfg && next_cfg[`CFG_BIT_STATE_MACHINE_RESET];
    assign wake = wr_cfg && cfg[`CFG_BIT_SLEEP]
                  && !next_cfg[`CFG_BIT_SLEEP];

    // sleep and reset sequencing of the phy state machines
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state <= SM_RUN;
        end else begin
            unique case (state)
                SM_RUN: begin
                    if (wr_cfg && next_cfg[`CFG_BIT_SLEEP]) begin
                        state <= SM_SLEEP;
                    end else if (state_machine_reset_start) begin
                        state <= SM_RESET;
                    end
                end
                // a sleep write overrides a running reset
                SM_RESET: begin
                    if (wr_cfg && next_cfg[`CFG_BIT_SLEEP]) begin
                        state <= SM_SLEEP;
                    end else if (timer_done) begin
                        state <= SM_RUN;
                    end
                end
                SM_SLEEP: begin
                    if (wake) begin
                        state <= SM_RESET;
                    end
                end
                // unused code falls back to run
                default: begin
                    state <= SM_RUN;
                end
            endcase
        end
    end

    // one timer serves software resets and the wake-up reset
    assign timer_start = state_machine_reset_start || wake;

    phy_cfg_reset_timer u_timer (
        .clk(clk),
        .rstn(rstn),
        .start(timer_start),
        .busy(timer_busy),
        .done(timer_done)
    );

    // line status inputs come from the analog side, outside the clock
    assign line_in = {line_link_100, line_signal_detector};

    generate
        for (genvar i = 0; i < 2; i++) begin : g_line
            logic [2:0] stages;
            logic clean;

            always_ff @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    stages <= 3'h0;
                end else begin
                    stages <= {stages[1:0], line_in[i]};
                end
            end

            // a change counts once the second and third stages agree
            always_ff @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    clean <= 1'b0;
                end else if (stages[1] == stages[2]) begin
                    clean <= stages[2];
                end
            end

            assign line_clean[i] = clean;
        end
    endgenerate

    assign sd_clean = line_clean[0];
    assign link_clean = line_clean[1];

    // control outputs to the datapath, all registered
    // encode and decode bypass, also forced by alignment bypass
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            encoder_bypass <= 1'b0;
        end else begin
            encoder_bypass <= cfg[`CFG_BIT_ENC_BYP]
                              || cfg[`CFG_BIT_ALN_BYP];
        end
    end

    // scramble bypass, also forced by alignment bypass
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            scrambler_bypass <= 1'b0;
        end else begin
            scrambler_bypass <= cfg[`CFG_BIT_SCR_BYP]
                                || cfg[`CFG_BIT_ALN_BYP];
        end
    end

    // symbol alignment bypass
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            alignment_bypass <= 1'b0;
        end else begin
            alignment_bypass <= cfg[`CFG_BIT_ALN_BYP];
        end
    end

    // debug force ORs with the live detector
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            signal_detect_ok <= 1'b0;
        end else begin
            signal_detect_ok <= cfg[`CFG_BIT_SD_FORCE]
                                || sd_clean;
        end
    end

    // copper when set, fibre when clear
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            media_copper <= 1'b1;
        end else begin
            media_copper <= cfg[`CFG_BIT_MEDIA];
        end
    end

    // forced link ORs with the live link status
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            link_100_good <= 1'b0;
        end else begin
            link_100_good <= cfg[`CFG_BIT_FLINK]
                             || link_clean;
        end
    end

    // permission for automatic reduced power down
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            auto_reduced_power_enable <= 1'b1;
        end else begin
            auto_reduced_power_enable <= cfg[`CFG_BIT_ARPD];
        end
    end

    // management frames accepted without preamble
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            preamble_suppression <= 1'b1;
        end else begin
            preamble_suppression <= cfg[`CFG_BIT_PRE_SUP];
        end
    end

    // state machines held in reset while resetting or asleep
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_machine_reset <= 1'b0;
        end else begin
            state_machine_reset <= (state != SM_RUN);
        end
    end

    // power down of all but oscillator and clocks
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sleep_mode <= 1'b0;
        end else begin
            sleep_mode <= (state == SM_SLEEP);
        end
    end
endmodule
`default_nettype wire

// ===== phy_cfg_defines.svh
// register offsets, field positions, reset values and timing counts
// assumes inclusion by bare name from the package and modules
`ifndef PHY_CFG_DEFINES_SVH
`define PHY_CFG_DEFINES_SVH

`define CFG_ADDR_W 5
`define CFG_OFF_VENDOR 5'h10
`define CFG_OFF_STATUS 5'h11
`define CFG_BIT_ENC_BYP 15
`define CFG_BIT_SCR_BYP 14
`define CFG_BIT_ALN_BYP 13
`define CFG_BIT_SD_FORCE 12
`define CFG_BIT_MEDIA 10
`define CFG_BIT_FLINK 7
`define CFG_BIT_ARPD 4
`define CFG_BIT_STATE_MACHINE_RESET 3
`define CFG_BIT_PRE_SUP 2
`define CFG_BIT_SLEEP 1
`define CFG_RW_MASK 16'hf49f
`define CFG_RESET_VAL 16'h0414
`define CFG_STATE_MACHINE_RESET_NS 40
`define CFG_STATE_MACHINE_RESET_CYC ((`CFG_STATE_MACHINE_RESET_NS + 3) / 4)

`endif

// ===== phy_cfg_pkg.sv
// types shared by the vendor configuration register files
// assumes phy_cfg_defines.svh is on the include path
`include "phy_cfg_defines.svh"
package phy_cfg_pkg;
    typedef logic [15:0] cfg_word_t;
    typedef logic [`CFG_ADDR_W-1:0] cfg_addr_t;
    typedef enum logic [1:0] {
        SM_RUN = 2'b00,
        SM_RESET = 2'b01,
        SM_SLEEP = 2'b10
    } sm_state_t;
endpackage

// ===== phy_cfg_reset_timer.sv
// pulse stretcher that holds the phy state machine reset for a fixed time
// assumes one clock domain and a one-cycle start pulse
`timescale 1ns/1ns
`default_nettype none
`include "phy_cfg_defines.svh"
module phy_cfg_reset_timer (
    input wire logic clk,
    input wire logic rstn,
    input wire logic start,
    output logic busy,
    output logic done
);
    logic [7:0] count;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            count <= 8'h00;
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                count <= 8'((`CFG_STATE_MACHINE_RESET_CYC) - 1);
                busy <= 1'b1;
            end else if (busy) begin
                if (count == 8'h00) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end else begin
                    count <= count - 8'h01;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ===== mgmt_host.sv
// management host model: classic wishbone master
// assumes the slave answers with ack or err on clk
`timescale 1ns/1ns
`default_nettype none
module mgmt_host (
    input wire logic clk,
    input wire logic ack,
    input wire logic err,
    input wire logic [31:0] rdat,
    output logic cyc,
    output logic stb,
    output logic we,
    output logic [4:0] adr,
    output logic [31:0] wdat,
    output logic [3:0] sel
);
    initial begin
        {cyc, stb, we, adr, wdat, sel} = '0;
    end
    // request held until ack or err is sampled, or until 50 further cycles pass without either
    task automatic xfer(input logic w, input logic [4:0] a,
            input logic [15:0] d, output logic [31:0] q,
            output logic e, output logic t);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {16'h0000, d};
        sel <= 4'h3;
        @(posedge clk);
        while (ack !== 1'b1 && err !== 1'b1 && n < 50) begin
            n++;
            @(posedge clk);
        end
        q = rdat;
        e = err;
        t = (n >= 50);
        cyc <= 1'b0;
        stb <= 1'b0;
        wdat <= ~wdat;
    endtask
endmodule
`default_nettype wire

// ===== phy_vendor_config_register_props.sv
// checker for the vendor configuration register ports
// assumes one clock domain, bound to the design below
`timescale 1ns/1ns
`default_nettype none
`include "phy_cfg_defines.svh"
module cfg_reg_props (
    input wire logic clk,
    input wire logic rstn,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [`CFG_ADDR_W-1:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic wb_err_o,
    input wire logic line_signal_detector,
    input wire logic encoder_bypass,
    input wire logic scrambler_bypass,
    input wire logic alignment_bypass,
    input wire logic signal_detect_ok,
    input wire logic state_machine_reset,
    input wire logic sleep_mode
);
    default clocking dc @(posedge clk); endclocking
    default disable iff (!rstn);
    bus_answer_a: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o |=>
        wb_ack_o || wb_err_o) else $error("request not answered");
    ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    reserved_zero_a: assert property (
        wb_ack_o && wb_adr_i == `CFG_OFF_VENDOR |->
        (wb_dat_o & 32'hffff0b61) == 32'h0) else $error("reserved bit set");
    align_both_a: assert property (
        alignment_bypass |-> encoder_bypass && scrambler_bypass)
        else $error("alignment bypass incomplete");
    detect_follow_a: assert property (
        line_signal_detector [*6] |=> signal_detect_ok)
        else $error("detector not followed");
    reset_hold_a: assert property (
        $rose(state_machine_reset) && !sleep_mode |->
        state_machine_reset [*8]) else $error("reset too short");
    reset_ends_a: assert property (
        state_machine_reset && !sleep_mode |->
        ##[1:20] (!state_machine_reset || sleep_mode))
        else $error("reset never ends");
    sleep_holds_a: assert property (
        sleep_mode |-> state_machine_reset) else $error("sleep without reset");
    cover property (wb_err_o);
    cover property ($rose(sleep_mode));
    cover property ($fell(state_machine_reset));
endmodule
bind phy_vendor_config_register cfg_reg_props props (.*);
`default_nettype wire

// ===== test_phy_vendor_config_register.sv
// bench for the vendor configuration register
// assumes mgmt_host as master and the bound checker
`timescale 1ns/1ns
`default_nettype none
`include "phy_cfg_defines.svh"
module test_phy_vendor_config_register;
    logic clk, rstn, sd, lk, cyc, stb, we, ack, err;
    logic [4:0] adr;
    logic [31:0] wd, dq;
    logic [3:0] sel;
    logic [9:0] o;
    int miscompares, samples_checked, n;
    mgmt_host host (.clk(clk), .ack(ack), .err(err), .rdat(dq), .cyc(cyc),
        .stb(stb), .we(we), .adr(adr), .wdat(wd), .sel(sel));
    phy_vendor_config_register dut (.clk(clk), .rstn(rstn),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_dat_i(wd), .wb_sel_i(sel), .wb_dat_o(dq), .wb_ack_o(ack),
        .wb_err_o(err), .line_signal_detector(sd), .line_link_100(lk),
        .encoder_bypass(o[9]), .scrambler_bypass(o[8]),
        .alignment_bypass(o[7]), .signal_detect_ok(o[6]),
        .media_copper(o[5]), .link_100_good(o[4]),
        .auto_reduced_power_enable(o[3]), .preamble_suppression(o[2]),
        .state_machine_reset(o[1]), .sleep_mode(o[0]));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic check(input string s, input logic [31:0] v, e);
        samples_checked++;
        if (v !== e) begin
            miscompares++;
            $display("wrong value %s exp %h seen %h", s, e, v);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // one bus access, err and read data compared
    task automatic acc(input logic w, input logic [4:0] a,
            input logic [15:0] d, e, input logic ee);
        logic [31:0] q;
        logic er, t;
        host.xfer(w, a, d, q, er, t);
        if (t) begin
            miscompares++;
            report_and_stop();
        end
        check("err", {31'h0, er}, {31'h0, ee});
        if (!w && !ee) check("data", q, {16'h0, e});
    endtask
    task automatic settle();
        n = 0;
        while (o[1] === 1'b1 && n < 100) begin
            n++;
            @(posedge clk);
        end
        check("reset busy", {31'h0, o[1]}, 32'h0);
    endtask
    initial begin
        rstn = 1'b0;
        sd = 1'b0;
        lk = 1'b0;
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        acc(0, 5'h10, 0, 16'h0414, 0);
        check("outs", o, 10'h02c);
        $display("test defaults done");
        acc(1, 5'h10, 16'hffe4, 0, 0);
        acc(0, 5'h10, 0, 16'hf484, 0);
        check("outs", o, 10'h3f4);
        acc(1, 5'h10, 0, 0, 0);
        @(posedge clk);
        check("outs", o, 10'h000);
        sd <= 1'b1;
        lk <= 1'b1;
        repeat (8) @(posedge clk);
        check("outs", o, 10'h050);
        acc(1, 5'h03, 16'hffff, 0, 1);
        acc(0, 5'h10, 0, 16'h0000, 0);
        $display("test fields done");
        acc(1, 5'h10, 16'h0008, 0, 0);
        repeat (2) @(posedge clk);
        check("reset", {31'h0, o[1]}, 32'h1);
        settle();
        check("reset len", {31'h0, n >= `CFG_STATE_MACHINE_RESET_CYC - 3}, 32'h1);
        acc(0, 5'h10, 0, 16'h0000, 0);
        acc(1, 5'h10, 16'h8402, 0, 0);
        acc(0, 5'h10, 0, 16'h8402, 0);
        check("outs", o, 10'h273);
        acc(0, 5'h11, 0, 16'h0007, 0);
        acc(1, 5'h10, 16'h8400, 0, 0);
        acc(0, 5'h10, 0, 16'h8400, 0);
        check("outs", o, 10'h272);
        settle();
        check("outs", o, 10'h270);
        $display("test reset and sleep done");
        report_and_stop();
    end
endmodule
`default_nettype wire
